// ===== rtl/stam_map.svh
// constants for the self-test alarm masking block
`ifndef STAM_MAP_SVH
`define STAM_MAP_SVH
`define STAM_NUM_PEERS       16
`define STAM_NUM_MINOR       9
// minor alarm bit positions
`define STAM_BIT_PORT_A      0
`define STAM_BIT_PORT_B      1
`define STAM_BIT_PORT_C      2
`define STAM_BIT_TIME        3
`define STAM_BIT_CODE        4
`define STAM_BIT_LOOP_A      5
`define STAM_BIT_LOOP_B      6
`define STAM_BIT_PEER_A      7
`define STAM_BIT_PEER_B      8
// register offsets (byte addresses)
`define STAM_OFS_ENABLE      12'h000
`define STAM_OFS_STATUS      12'h004
`define STAM_OFS_MASK        12'h008
`define STAM_OFS_OPERAND     12'h00C
`define STAM_OFS_PEER_A      12'h010
`define STAM_OFS_PEER_B      12'h014
`define STAM_OFS_MAJOR       12'h018
// reset values
`define STAM_RST_ENABLE      9'h019
`define STAM_RST_MASK        10'h000
`endif

// ===== rtl/stam_pkg.sv
// types for the self-test alarm masking block
package stam_pkg;
  typedef logic [8:0] stam_minor_type;
  typedef logic [9:0] stam_event_type;
endpackage : stam_pkg

// ===== rtl/stam_top.sv
// self-test alarm masking with apb settings, event status and interrupt
`timescale 1ns/1ps
`include "stam_map.svh"

module stam_top #(
  parameter int NUM_MAJOR = 4,
  parameter int NUM_PEERS = `STAM_NUM_PEERS
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 NET_PORT_A_FAIL,
  input  wire logic                 NET_PORT_B_FAIL,
  input  wire logic                 NET_PORT_C_FAIL,
  input  wire logic                 NET_TIME_FAIL,
  input  wire logic                 TIME_CODE_FAIL,
  input  wire logic                 CHAN_A_LOOP_OPEN,
  input  wire logic                 CHAN_B_LOOP_OPEN,
  input  wire logic [NUM_PEERS-1:0] CHAN_A_PEER_N_MISSING,
  input  wire logic [NUM_PEERS-1:0] CHAN_B_PEER_N_MISSING,
  input  wire logic [NUM_MAJOR-1:0] MAJOR_FAIL,
  output logic      [8:0]           MINOR_OPERAND,
  output logic      [NUM_MAJOR-1:0] MAJOR_OPERAND,
  output logic      [NUM_PEERS-1:0] CHAN_A_PEER_OPERAND,
  output logic      [NUM_PEERS-1:0] CHAN_B_PEER_OPERAND,
  output logic                      ANY_MINOR,
  output logic                      ANY_SELF_TEST,
  output logic      [8:0]           EVENT_PULSE,
  output logic                      IRQ
);

  stam_pkg::stam_minor_type enable_r;
  stam_pkg::stam_minor_type raw_minor;
  stam_pkg::stam_minor_type gated_minor;
  stam_pkg::stam_minor_type prev_minor_r;
  stam_pkg::stam_event_type status_r;
  stam_pkg::stam_event_type mask_r;
  stam_pkg::stam_event_type status_set;
  logic [NUM_PEERS-1:0]     peer_a_r;
  logic [NUM_PEERS-1:0]     peer_b_r;
  logic                     major_any;
  logic                     major_rise;
  logic                     prev_major_r;
  logic                     wr_en;
  logic                     rd_en;
  logic                     addr_ok;
  logic [31:0]              rd_nxt;

  // per-channel peer flags held in flops so the operands come from registers
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      peer_a_r <= '0;
      peer_b_r <= '0;
    end else begin
      peer_a_r <= CHAN_A_PEER_N_MISSING;
      peer_b_r <= CHAN_B_PEER_N_MISSING;
    end
  end

  always_comb begin
    raw_minor                   = '0;
    raw_minor[`STAM_BIT_PORT_A] = NET_PORT_A_FAIL;
    raw_minor[`STAM_BIT_PORT_B] = NET_PORT_B_FAIL;
    raw_minor[`STAM_BIT_PORT_C] = NET_PORT_C_FAIL;
    raw_minor[`STAM_BIT_TIME]   = NET_TIME_FAIL;
    raw_minor[`STAM_BIT_CODE]   = TIME_CODE_FAIL;
    raw_minor[`STAM_BIT_LOOP_A] = CHAN_A_LOOP_OPEN;
    raw_minor[`STAM_BIT_LOOP_B] = CHAN_B_LOOP_OPEN;
    raw_minor[`STAM_BIT_PEER_A] = |peer_a_r;
    raw_minor[`STAM_BIT_PEER_B] = |peer_b_r;
  end

  // one gate per alarm; a disabled alarm reaches nothing downstream, but its raw peer flags still read back at the peer registers
  genvar gi;
  generate
    for (gi = 0; gi < `STAM_NUM_MINOR; gi++) begin : g_gate
      assign gated_minor[gi] = raw_minor[gi] & enable_r[gi];
    end
  endgenerate

  // majors bypass the enables entirely
  assign major_any  = |MAJOR_FAIL;
  assign major_rise = major_any & ~prev_major_r;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      MINOR_OPERAND       <= '0;
      MAJOR_OPERAND       <= '0;
      CHAN_A_PEER_OPERAND <= '0;
      CHAN_B_PEER_OPERAND <= '0;
      ANY_MINOR           <= 1'b0;
      ANY_SELF_TEST       <= 1'b0;
    end else begin
      MINOR_OPERAND       <= gated_minor;
      MAJOR_OPERAND       <= MAJOR_FAIL;
      CHAN_A_PEER_OPERAND <= enable_r[`STAM_BIT_PEER_A] ? peer_a_r : '0;
      CHAN_B_PEER_OPERAND <= enable_r[`STAM_BIT_PEER_B] ? peer_b_r : '0;
      ANY_MINOR           <= |gated_minor;
      ANY_SELF_TEST       <= (|gated_minor) | major_any;
    end
  end

  // events: rising edge of each gated alarm, one pulse per onset
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      prev_minor_r <= '0;
      prev_major_r <= 1'b0;
      EVENT_PULSE  <= '0;
    end else begin
      prev_minor_r <= gated_minor;
      prev_major_r <= major_any;
      EVENT_PULSE  <= gated_minor & ~prev_minor_r;
    end
  end

  // bit 9 of status records a major onset
  assign status_set = {major_rise, gated_minor & ~prev_minor_r};

  // apb: zero wait states, answer in the access cycle
  assign wr_en   = PSEL & PENABLE & PWRITE;
  assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
  assign addr_ok = (PADDR == `STAM_OFS_ENABLE) || (PADDR == `STAM_OFS_STATUS) ||
                   (PADDR == `STAM_OFS_MASK) || (PADDR == `STAM_OFS_OPERAND) ||
                   (PADDR == `STAM_OFS_PEER_A) || (PADDR == `STAM_OFS_PEER_B) ||
                   (PADDR == `STAM_OFS_MAJOR);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      enable_r <= `STAM_RST_ENABLE;
      mask_r   <= `STAM_RST_MASK;
    end else if (wr_en) begin
      if (PADDR == `STAM_OFS_ENABLE) begin
        enable_r <= PWDATA[8:0];
      end
      if (PADDR == `STAM_OFS_MASK) begin
        mask_r <= PWDATA[9:0];
      end
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      status_r <= '0;
    end else if (wr_en && PADDR == `STAM_OFS_STATUS) begin
      status_r <= (status_r & ~PWDATA[9:0]) | status_set;
    end else begin
      status_r <= status_r | status_set;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(status_r & mask_r);
    end
  end

  always_comb begin
    rd_nxt = 32'h00000000;
    case (PADDR)
      `STAM_OFS_ENABLE:  rd_nxt[8:0] = enable_r;
      `STAM_OFS_STATUS:  rd_nxt[9:0] = status_r;
      `STAM_OFS_MASK:    rd_nxt[9:0] = mask_r;
      `STAM_OFS_OPERAND: rd_nxt[8:0] = gated_minor;
      `STAM_OFS_PEER_A:  rd_nxt[NUM_PEERS-1:0] = peer_a_r;
      `STAM_OFS_PEER_B:  rd_nxt[NUM_PEERS-1:0] = peer_b_r;
      `STAM_OFS_MAJOR:   rd_nxt[NUM_MAJOR-1:0] = MAJOR_FAIL;
      default:           rd_nxt = 32'h00000000;
    endcase
  end

  // read data captured in setup so it stands through the access cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      if (rd_en) begin
        PRDATA <= rd_nxt;
      end
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
    end
  end

  property p_major_pass;
    @(posedge CLK_SYS) disable iff (RST)
      major_any |=> ANY_SELF_TEST;
  endproperty
  a_major_pass: assert property (p_major_pass) else $error("major alarm missed summary");

  property p_port_a_off;
    @(posedge CLK_SYS) disable iff (RST)
      !enable_r[`STAM_BIT_PORT_A] |=> !MINOR_OPERAND[`STAM_BIT_PORT_A] && !EVENT_PULSE[`STAM_BIT_PORT_A];
  endproperty
  a_port_a_off: assert property (p_port_a_off) else $error("disabled port a alarm leaked");

  property p_port_b_off;
    @(posedge CLK_SYS) disable iff (RST)
      !enable_r[`STAM_BIT_PORT_B] |=> !MINOR_OPERAND[`STAM_BIT_PORT_B];
  endproperty
  a_port_b_off: assert property (p_port_b_off) else $error("disabled port b alarm leaked");

  property p_port_c_off;
    @(posedge CLK_SYS) disable iff (RST)
      !enable_r[`STAM_BIT_PORT_C] |=> !MINOR_OPERAND[`STAM_BIT_PORT_C];
  endproperty
  a_port_c_off: assert property (p_port_c_off) else $error("disabled port c alarm leaked");

  property p_time_off;
    @(posedge CLK_SYS) disable iff (RST)
      !enable_r[`STAM_BIT_TIME] |=> !MINOR_OPERAND[`STAM_BIT_TIME];
  endproperty
  a_time_off: assert property (p_time_off) else $error("disabled time alarm leaked");

  property p_code_off;
    @(posedge CLK_SYS) disable iff (RST)
      !enable_r[`STAM_BIT_CODE] |=> !MINOR_OPERAND[`STAM_BIT_CODE];
  endproperty
  a_code_off: assert property (p_code_off) else $error("disabled time code alarm leaked");

  sequence s_onset;
    !gated_minor[`STAM_BIT_PORT_A] ##1 gated_minor[`STAM_BIT_PORT_A];
  endsequence

  property p_event;
    @(posedge CLK_SYS) disable iff (RST)
      s_onset |=> EVENT_PULSE[`STAM_BIT_PORT_A] && ANY_MINOR ##1 !EVENT_PULSE[`STAM_BIT_PORT_A];
  endproperty
  a_event: assert property (p_event) else $error("enabled alarm onset not logged once");

  property p_loop_a;
    @(posedge CLK_SYS) disable iff (RST)
      enable_r[`STAM_BIT_LOOP_A] && CHAN_A_LOOP_OPEN |=> MINOR_OPERAND[`STAM_BIT_LOOP_A];
  endproperty
  a_loop_a: assert property (p_loop_a) else $error("loop a alarm missing");

  property p_loop_b;
    @(posedge CLK_SYS) disable iff (RST)
      enable_r[`STAM_BIT_LOOP_B] && CHAN_B_LOOP_OPEN |=> MINOR_OPERAND[`STAM_BIT_LOOP_B];
  endproperty
  a_loop_b: assert property (p_loop_b) else $error("loop b alarm missing");

  property p_peer_a;
    @(posedge CLK_SYS) disable iff (RST)
      enable_r[`STAM_BIT_PEER_A] && (|CHAN_A_PEER_N_MISSING) ##1 enable_r[`STAM_BIT_PEER_A]
        |=> MINOR_OPERAND[`STAM_BIT_PEER_A];
  endproperty
  a_peer_a: assert property (p_peer_a) else $error("peer a missing alarm absent");

  property p_peer_b;
    @(posedge CLK_SYS) disable iff (RST)
      enable_r[`STAM_BIT_PEER_B] && (|CHAN_B_PEER_N_MISSING) ##1 enable_r[`STAM_BIT_PEER_B]
        |=> MINOR_OPERAND[`STAM_BIT_PEER_B];
  endproperty
  a_peer_b: assert property (p_peer_b) else $error("peer b missing alarm absent");

  property p_peer_or;
    @(posedge CLK_SYS) disable iff (RST)
      (CHAN_A_PEER_N_MISSING == '0) ##1 !enable_r[`STAM_BIT_PEER_A] || (CHAN_A_PEER_N_MISSING == '0)
        |=> !MINOR_OPERAND[`STAM_BIT_PEER_A];
  endproperty
  a_peer_or: assert property (p_peer_or) else $error("peer a alarm with no flag set");

  property p_summary;
    @(posedge CLK_SYS) disable iff (RST)
      ANY_SELF_TEST == (ANY_MINOR || (MAJOR_OPERAND != '0));
  endproperty
  a_summary: assert property (p_summary) else $error("summary alarm mismatch");

  sequence s_major_onset;
    !major_any ##1 major_any;
  endsequence

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence

  property p_major_operand;
    @(posedge CLK_SYS) disable iff (RST)
      (enable_r == '0) |=> MAJOR_OPERAND == $past(MAJOR_FAIL);
  endproperty
  a_major_operand: assert property (p_major_operand) else $error("major operand masked by enables");

  property p_major_log;
    @(posedge CLK_SYS) disable iff (RST)
      s_major_onset |=> status_r[9];
  endproperty
  a_major_log: assert property (p_major_log) else $error("major onset not recorded");

  property p_quiet;
    @(posedge CLK_SYS) disable iff (RST)
      ((raw_minor & enable_r) == '0) && !major_any |=> !ANY_MINOR && !ANY_SELF_TEST && (EVENT_PULSE == '0);
  endproperty
  a_quiet: assert property (p_quiet) else $error("summary raised with no enabled alarm");

  property p_peer_a_off;
    @(posedge CLK_SYS) disable iff (RST)
      !enable_r[`STAM_BIT_PEER_A] |=> (CHAN_A_PEER_OPERAND == '0) && !MINOR_OPERAND[`STAM_BIT_PEER_A];
  endproperty
  a_peer_a_off: assert property (p_peer_a_off) else $error("disabled peer a operand leaked");

  property p_peer_b_off;
    @(posedge CLK_SYS) disable iff (RST)
      !enable_r[`STAM_BIT_PEER_B] |=> (CHAN_B_PEER_OPERAND == '0) && !MINOR_OPERAND[`STAM_BIT_PEER_B];
  endproperty
  a_peer_b_off: assert property (p_peer_b_off) else $error("disabled peer b operand leaked");

  property p_event_off;
    @(posedge CLK_SYS) disable iff (RST)
      1'b1 |=> (EVENT_PULSE & ~$past(enable_r)) == '0;
  endproperty
  a_event_off: assert property (p_event_off) else $error("disabled alarm logged an event");

  // a clear arriving with a fresh onset must not lose the event
  property p_status_hold;
    @(posedge CLK_SYS) disable iff (RST)
      status_set[`STAM_BIT_PORT_A] |=> status_r[`STAM_BIT_PORT_A];
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("onset lost against clear");

  property p_irq;
    @(posedge CLK_SYS) disable iff (RST)
      (|(status_r & mask_r)) |=> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing for unmasked status");

  property p_apb_ready;
    @(posedge CLK_SYS) disable iff (RST)
      s_setup |=> PREADY ##1 !PREADY;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("bus answer not a single cycle");

endmodule : stam_top

// ===== sim/tb_stam_top.sv
// self-checking bench for the self-test alarm masking block
`timescale 1ns/1ps
`include "stam_map.svh"
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module tb_stam_top;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, snap_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0]  raw_in;
  logic [15:0] pa_in, pb_in, pa_op, pb_op, lfsr_r;
  logic [3:0]  major_in, major_op;
  logic [8:0]  minor_op, ev_pulse, ev_acc;
  logic        any_minor, any_st, irq;
  logic [32:0] rd_q[$];
  logic [32:0] rd_e;
  logic [56:0] snap_e, snap_g;
  logic [56:0] snap_q[$];
  int          num_errors, tests_run, cyc;

  stam_top #(.NUM_MAJOR(4), .NUM_PEERS(16)) dut (.CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .NET_PORT_A_FAIL(raw_in[0]), .NET_PORT_B_FAIL(raw_in[1]), .NET_PORT_C_FAIL(raw_in[2]),
    .NET_TIME_FAIL(raw_in[3]), .TIME_CODE_FAIL(raw_in[4]), .CHAN_A_LOOP_OPEN(raw_in[5]),
    .CHAN_B_LOOP_OPEN(raw_in[6]), .CHAN_A_PEER_N_MISSING(pa_in), .CHAN_B_PEER_N_MISSING(pb_in),
    .MAJOR_FAIL(major_in), .MINOR_OPERAND(minor_op), .MAJOR_OPERAND(major_op), .CHAN_A_PEER_OPERAND(pa_op),
    .CHAN_B_PEER_OPERAND(pb_op), .ANY_MINOR(any_minor), .ANY_SELF_TEST(any_st), .EVENT_PULSE(ev_pulse),
    .IRQ(irq));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [56:0] mk(input logic [15:0] pb, input logic [15:0] pa, input logic [3:0] mj,
                                     input logic i, input logic st, input logic mn, input logic [8:0] op,
                                     input logic [8:0] ev);
    return {pb, pa, mj, i, st, mn, op, ev};
  endfunction : mk

  task print_verdict;
    $display("errors %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp_rd);
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    if (!wr) rd_q.push_back(exp_rd);
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task snap(input logic [56:0] e);
    @(posedge clk_sys);
    snap_q.push_back(e);
    snap_req <= 1'b1;
    @(posedge clk_sys);
    snap_req <= 1'b0;
  endtask : snap

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // watcher: takes the oldest note whenever a result shows
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict();
    end
    // pop once per result so a mismatch cannot drain a second note
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      rd_e = rd_q.pop_front();
      `CHK({pslverr, prdata}, rd_e)
    end
    if (snap_req) begin
      snap_e = snap_q.pop_front();
      snap_g = {pb_op, pa_op, major_op, irq, any_st, any_minor, minor_op, ev_acc | ev_pulse};
      `CHK(snap_g, snap_e)
    end
    // outputs are unknown before the first reset edge, so reset clears the accumulator
    ev_acc <= (snap_req || rst) ? 9'h000 : (ev_acc | ev_pulse);
  end

  initial begin
    logic [8:0] en, raw, g;
    logic [9:0] msk;
    logic [15:0] pa, pb;
    int b;
    {rst, psel, penable, pwrite, paddr, pwdata, raw_in, pa_in, pb_in, major_in} = '0;
    {num_errors, tests_run, cyc, snap_req, ev_acc} = '0;
    lfsr_r = 16'h0041;
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `STAM_OFS_ENABLE, 32'h0, {1'b0, 32'h0000_0019});
    apb(1'b0, `STAM_OFS_MASK, 32'h0, 33'h0);
    apb(1'b0, `STAM_OFS_STATUS, 32'h0, 33'h0);
    apb(1'b0, 12'h01C, 32'h0, {1'b1, 32'h0}); // unmapped place reads zero with an error
    // each alarm seen with its own enable off, then on, among random others
    for (int i = 0; i < 18; i++) begin
      b = i / 2;
      lfsr_r = lfsr_next(lfsr_r); en = lfsr_r[8:0]; en[b] = i[0];
      lfsr_r = lfsr_next(lfsr_r); raw = lfsr_r[8:0]; raw[b] = 1'b1;
      lfsr_r = lfsr_next(lfsr_r); msk = lfsr_r[9:0];
      pa = raw[7] ? 16'h0001 << lfsr_r[3:0] : 16'h0000;
      pb = raw[8] ? 16'h8000 >> lfsr_r[7:4] : 16'h0000;
      g = en & raw;
      apb(1'b1, `STAM_OFS_ENABLE, {23'h0, en}, 33'h0);
      apb(1'b1, `STAM_OFS_MASK, {22'h0, msk}, 33'h0);
      apb(1'b0, `STAM_OFS_MASK, 32'h0, {23'h0, msk});
      snap(57'h0);
      raw_in <= raw[6:0]; pa_in <= pa; pb_in <= pb;
      repeat (4) @(posedge clk_sys);
      snap(mk(en[8] ? pb : 16'h0, en[7] ? pa : 16'h0, 4'h0, |(g & msk[8:0]), |g, |g, g, g));
      apb(1'b0, `STAM_OFS_STATUS, 32'h0, {24'h0, g});
      apb(1'b0, `STAM_OFS_OPERAND, 32'h0, {24'h0, g});
      apb(1'b0, `STAM_OFS_PEER_A, 32'h0, {17'h0, pa});
      apb(1'b0, `STAM_OFS_PEER_B, 32'h0, {17'h0, pb});
      raw_in <= 7'h00; pa_in <= 16'h0; pb_in <= 16'h0;
      repeat (4) @(posedge clk_sys);
      // status is sticky, so the interrupt outlives the alarm
      snap(mk(16'h0, 16'h0, 4'h0, |(g & msk[8:0]), 1'b0, 1'b0, 9'h0, 9'h0));
      apb(1'b1, `STAM_OFS_STATUS, 32'h0000_03FF, 33'h0);
      snap(57'h0);
    end
    // majors pass with every enable off
    apb(1'b1, `STAM_OFS_ENABLE, 32'h0, 33'h0);
    apb(1'b1, `STAM_OFS_MASK, 32'h0000_0200, 33'h0);
    lfsr_r = lfsr_next(lfsr_r);
    major_in <= lfsr_r[3:0] | 4'h1;
    repeat (4) @(posedge clk_sys);
    snap(mk(16'h0, 16'h0, lfsr_r[3:0] | 4'h1, 1'b1, 1'b1, 1'b0, 9'h0, 9'h0));
    apb(1'b0, `STAM_OFS_MAJOR, 32'h0, {29'h0, lfsr_r[3:0] | 4'h1});
    apb(1'b0, `STAM_OFS_STATUS, 32'h0, {1'b0, 32'h0000_0200});
    major_in <= 4'h0;
    apb(1'b1, `STAM_OFS_STATUS, 32'h0000_03FF, 33'h0);
    repeat (2) @(posedge clk_sys);
    snap(57'h0);
    print_verdict();
  end
endmodule : tb_stam_top
